//--- logic/accel_status_pkg.sv
// shared constants and types for the status and interrupt-flag block
package accel_status_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets on the host register port
    localparam logic [7:0] mode_queue_status_addr = 8'h08;
    localparam logic [7:0] irq_flag_status_addr   = 8'h09;

    // reset values
    localparam logic [7:0] mode_queue_status_rst  = 8'h00;
    localparam logic [7:0] irq_flag_status_rst    = 8'h00;
    localparam logic       queue_empty_rst        = 1'b1;
    localparam logic [7:0] rdata_rst              = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions in the mode and queue status register
    localparam int mode_lsb            = 0;
    localparam int mode_width          = 3;
    localparam int sample_arrived_bit  = 3;
    localparam int queue_empty_bit     = 4;
    localparam int queue_full_bit      = 5;
    localparam int queue_thresh_bit    = 6;
    localparam int any_pending_bit     = 7;

    // field positions in the interrupt flag register
    localparam int flag_lsb            = 2;
    localparam int flag_count          = 6;
    localparam int wake_idx            = 0;
    localparam int acquired_idx        = 1;
    localparam int empty_idx           = 2;
    localparam int full_idx            = 3;
    localparam int thresh_idx          = 4;
    localparam int activity_idx        = 5;

    ////////////////////////////////////////////////////////////////////////////////
    // mode codes as reported to the host
    localparam logic [2:0] code_sleep      = 3'h0;
    localparam logic [2:0] code_standby    = 3'h1;
    localparam logic [2:0] code_watch      = 3'h2;
    localparam logic [2:0] code_continuous_wake      = 3'h5;
    localparam logic [2:0] code_watch_samp = 3'h6;
    localparam logic [2:0] code_burst      = 3'h7;

    // one-hot operating states
    typedef enum logic [5:0] {
        st_sleep      = 6'h01,
        st_standby    = 6'h02,
        st_watch      = 6'h04,
        st_continuous_wake      = 6'h08,
        st_watch_samp = 6'h10,
        st_burst      = 6'h20
    } mode_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // timing and counts
    localparam int          mode_lag_cycles = 2;      // heartbeat edges before the mode field follows
    localparam int          queue_depth     = 32;     // three-axis samples
    localparam int          count_width     = 6;      // queue occupancy 0..32
    localparam int          thresh_width    = 5;
    localparam logic [7:0]  burst_min       = 8'h01;
    localparam logic [7:0]  burst_max       = 8'hfe;  // 1..254 counted, other values continuous

endpackage : accel_status_pkg

//--- logic/irq_bus_if.sv
// carrier between the flag controller and the sticky flag bank
`timescale 1ns/100ps
interface irq_bus_if #(
    parameter int N = 6
);
    logic [N-1:0] cond;     // event levels or pulses, flag sets on their rising edge
    logic [N-1:0] enable;   // per-flag enable
    logic         clear;    // one-cycle clear of every flag
    logic [N-1:0] flags;    // sticky flags

    modport bank (input cond, input enable, input clear, output flags);
    modport ctrl (output cond, output enable, output clear, input flags);
endinterface : irq_bus_if

//--- logic/sticky_flag_bank.sv
// sticky interrupt flags, each set by the rising edge of its own condition
`timescale 1ns/100ps
module sticky_flag_bank #(
    parameter int N = 6
) (
    input  wire logic clk,
    input  wire logic rst,
    irq_bus_if.bank   bus
);

    logic [N-1:0] cond_prev_q;
    logic [N-1:0] flag_q;

    ////////////////////////////////////////////////////////////////////////////////
    // per flag: edge detect, enable gate, set beats clear
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            logic set_now;
            // a level must drop and rise again before it can retrigger
            assign set_now = bus.cond[i] & ~cond_prev_q[i] & bus.enable[i];

            always_ff @(posedge clk) begin
                if (rst) begin
                    cond_prev_q[i] <= 1'b0;
                end else begin
                    cond_prev_q[i] <= bus.cond[i];
                end
            end

            // an event in the clearing cycle is kept
            always_ff @(posedge clk) begin
                if (rst) begin
                    flag_q[i] <= 1'b0;
                end else if (set_now) begin
                    flag_q[i] <= 1'b1;
                end else if (bus.clear) begin
                    flag_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign bus.flags = flag_q;

endmodule : sticky_flag_bank

//--- logic/activity_gate.sv
// arms the activity detector in watch-and-sample mode and freezes the queue
`timescale 1ns/100ps
module activity_gate (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic in_watch_samp,
    input  wire logic activity_raw,
    input  wire logic flag_cleared,
    input  wire logic rearm_on_clear,
    input  wire logic freeze_enable,
    input  wire logic stream_enable,
    output logic      fire,
    output logic      armed_q,
    output logic      freeze_q
);

    // fires once, then holds off until re-armed
    assign fire = in_watch_samp & armed_q & activity_raw;

    ////////////////////////////////////////////////////////////////////////////////
    // re-arm by leaving the mode, or by the flag clear when that option is on
    always_ff @(posedge clk) begin
        if (rst) begin
            armed_q <= 1'b1;
        end else if (!in_watch_samp) begin
            armed_q <= 1'b1;
        end else if (fire) begin
            armed_q <= 1'b0;
        end else if (flag_cleared && rearm_on_clear) begin
            armed_q <= 1'b1;
        end
    end

    // freeze holds the captured history until the detector is re-armed
    always_ff @(posedge clk) begin
        if (rst) begin
            freeze_q <= 1'b0;
        end else if (fire && freeze_enable && stream_enable) begin
            freeze_q <= 1'b1;
        end else if (!in_watch_samp || (flag_cleared && rearm_on_clear)) begin
            freeze_q <= 1'b0;
        end
    end

endmodule : activity_gate

//--- logic/accel_status_irq.sv
// mode tracking, status registers and interrupt flags of the motion sensor
// How it works
// - reported mode field lags the internal mode by fewer than three heartbeat edges
// - mode codes: 000,001,010,101,110,111; 011 and 100 are reserved
// - activity-watch mode does no queue work and jumps to continuous wake on activity
// - burst mode counts 1..254 samples then sleeps, or samples without end
// - sample_arrived bit sets on each new sample until status is read
// - queue_empty_level is one while queue is empty, and one after reset
// - queue_threshold_level is one while queued count is at least the threshold
// - any_irq_pending is the OR of all interrupt flags
// - a flag can only set while its enable bit is one
// - over I2C flags clear on read by default, or on write if selected
// - over SPI flags clear when the flag register is written
// - feature bit 4 picks clear-on-read or clear-on-write over I2C; over SPI it has no effect
// - wake_irq sets on every automatic watch to continuous-wake move
// - sample_acquired_irq sets on new samples in continuous wake or burst only
// - queue_empty_irq sets on empty, retriggers after non-empty then empty
// - queue_full_irq sets at 32 samples, retriggers after leaving full
// - queue_threshold_irq sets when count reaches the five-bit threshold
// - activity_in_wake_irq sets on detection in watch-and-sample; detector then halts
// - with the re-arm option, clearing that flag also re-arms the detector
// - with freeze and stream mode, detection stops queue capture
`timescale 1ns/100ps
module accel_status_irq #(
    parameter int COUNT_W = accel_status_pkg::count_width
) (
    input  wire logic               clk,
    input  wire logic               rst,
    // host register port, already decoded from the serial link
    input  wire logic               reg_rd,
    input  wire logic               reg_wr,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               host_is_spi,
    output logic [7:0]              reg_rdata,
    output logic                    reg_rvalid,
    // mode command from the mode-control register
    input  wire logic               mode_cmd_wr,
    input  wire logic [2:0]         mode_cmd,
    input  wire logic [7:0]         burst_len,
    // configuration bits held in neighbouring registers
    input  wire logic [5:0]         irq_enable,
    input  wire logic               wr_clear_sel,
    input  wire logic               rearm_on_clear,
    input  wire logic               freeze_enable,
    input  wire logic               stream_enable,
    input  wire logic [4:0]         queue_thresh,
    // datapath events
    input  wire logic               sample_written,
    input  wire logic               activity_raw,
    input  wire logic [COUNT_W-1:0] queue_count,
    // state shown to the rest of the device
    output logic [2:0]              mode_code,
    output logic                    any_irq_pending,
    output logic                    queue_capture_en,
    output logic                    detector_armed
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    accel_status_pkg::mode_state_t state_q;
    accel_status_pkg::mode_state_t state_d;

    logic [2:0]   code_now;
    logic [2:0]   lag_q [accel_status_pkg::mode_lag_cycles];
    logic [7:0]   burst_cnt_q;
    logic         burst_counted;
    logic         burst_done;
    logic         watch_wake;
    logic         auto_wake;
    logic         act_fire;
    logic         freeze_q;
    logic         armed_q;
    logic         sample_arrived_q;
    logic         queue_empty_q;
    logic         queue_full_q;
    logic         queue_thresh_q;
    logic         pending_q;
    logic         capture_q;
    logic [7:0]   rdata_q;
    logic         rvalid_q;
    logic         rd_status;
    logic         rd_flags;
    logic         wr_flags;
    logic         clear_req;
    logic         cmd_legal;
    logic         cmd_take;
    logic         is_empty;
    logic         is_full;
    logic         at_thresh;
    logic         acq_mode;
    logic [7:0]   status_word;
    logic [7:0]   flag_word;

    irq_bus_if #(.N(accel_status_pkg::flag_count)) irq_bus ();

    ////////////////////////////////////////////////////////////////////////////////
    // register port decode
    assign rd_status = reg_rd && (reg_addr == accel_status_pkg::mode_queue_status_addr);
    assign rd_flags  = reg_rd && (reg_addr == accel_status_pkg::irq_flag_status_addr);
    assign wr_flags  = reg_wr && (reg_addr == accel_status_pkg::irq_flag_status_addr);

    // spi always clears by write; i2c reads by default, writes when selected
    assign clear_req = (host_is_spi && wr_flags)
                     | (!host_is_spi && wr_clear_sel && wr_flags)
                     | (!host_is_spi && !wr_clear_sel && rd_flags);

    ////////////////////////////////////////////////////////////////////////////////
    // mode state machine
    // reserved codes are dropped so the state never leaves the legal set
    assign cmd_legal = (mode_cmd == accel_status_pkg::code_sleep)
                    || (mode_cmd == accel_status_pkg::code_standby)
                    || (mode_cmd == accel_status_pkg::code_watch)
                    || (mode_cmd == accel_status_pkg::code_continuous_wake)
                    || (mode_cmd == accel_status_pkg::code_watch_samp)
                    || (mode_cmd == accel_status_pkg::code_burst);

    assign watch_wake = (state_q == accel_status_pkg::st_watch) && activity_raw;

    // a command beats the auto move, and then no wake flag
    assign cmd_take  = mode_cmd_wr && cmd_legal;
    assign auto_wake = watch_wake && !cmd_take;

    // lengths outside 1..254 mean the burst never ends by itself
    assign burst_counted = (burst_len >= accel_status_pkg::burst_min)
                        && (burst_len <= accel_status_pkg::burst_max);
    assign burst_done    = (state_q == accel_status_pkg::st_burst) && burst_counted
                        && sample_written && ((burst_cnt_q + 8'h01) >= burst_len);

    // a host command beats an automatic move in the same cycle
    always_comb begin
        state_d = state_q;
        if (cmd_take) begin
            case (mode_cmd)
                accel_status_pkg::code_sleep:      state_d = accel_status_pkg::st_sleep;
                accel_status_pkg::code_standby:    state_d = accel_status_pkg::st_standby;
                accel_status_pkg::code_watch:      state_d = accel_status_pkg::st_watch;
                accel_status_pkg::code_continuous_wake:      state_d = accel_status_pkg::st_continuous_wake;
                accel_status_pkg::code_watch_samp: state_d = accel_status_pkg::st_watch_samp;
                accel_status_pkg::code_burst:      state_d = accel_status_pkg::st_burst;
                default:                           state_d = state_q;
            endcase
        end else if (watch_wake) begin
            state_d = accel_status_pkg::st_continuous_wake;
        end else if (burst_done) begin
            state_d = accel_status_pkg::st_sleep;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= accel_status_pkg::st_sleep;
        end else begin
            state_q <= state_d;
        end
    end

    // burst sample counter, restarted on every entry into burst mode
    // saturates at 0xff so a free-running burst never wraps
    always_ff @(posedge clk) begin
        if (rst) begin
            burst_cnt_q <= 8'h00;
        end else if (state_d != accel_status_pkg::st_burst || state_q != accel_status_pkg::st_burst) begin
            burst_cnt_q <= 8'h00;
        end else if (sample_written && burst_cnt_q != 8'hff) begin
            burst_cnt_q <= burst_cnt_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state to code
    always_comb begin
        case (state_q)
            accel_status_pkg::st_sleep:      code_now = accel_status_pkg::code_sleep;
            accel_status_pkg::st_standby:    code_now = accel_status_pkg::code_standby;
            accel_status_pkg::st_watch:      code_now = accel_status_pkg::code_watch;
            accel_status_pkg::st_continuous_wake:      code_now = accel_status_pkg::code_continuous_wake;
            accel_status_pkg::st_watch_samp: code_now = accel_status_pkg::code_watch_samp;
            accel_status_pkg::st_burst:      code_now = accel_status_pkg::code_burst;
            default:                         code_now = accel_status_pkg::code_sleep;
        endcase
    end

    // short pipeline models the settling of the mode field, kept below three edges
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int k = 0; k < accel_status_pkg::mode_lag_cycles; k++) begin
                lag_q[k] <= accel_status_pkg::code_sleep;
            end
        end else begin
            lag_q[0] <= code_now;
            for (int k = 1; k < accel_status_pkg::mode_lag_cycles; k++) begin
                lag_q[k] <= lag_q[k-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // queue levels, registered so the status word is stable for a read
    // full uses >= so an overcount still reads full
    assign is_empty  = (queue_count == '0);
    assign is_full   = (queue_count >= COUNT_W'(accel_status_pkg::queue_depth));
    assign at_thresh = (queue_count >= COUNT_W'(queue_thresh));

    always_ff @(posedge clk) begin
        if (rst) begin
            queue_empty_q  <= accel_status_pkg::queue_empty_rst;
            queue_full_q   <= 1'b0;
            queue_thresh_q <= 1'b0;
        end else begin
            queue_empty_q  <= is_empty;
            queue_full_q   <= is_full;
            queue_thresh_q <= at_thresh;
        end
    end

    // sample_arrived ignores every enable; a sample in the reading cycle survives
    always_ff @(posedge clk) begin
        if (rst) begin
            sample_arrived_q <= 1'b0;
        end else if (sample_written) begin
            sample_arrived_q <= 1'b1;
        end else if (rd_status) begin
            sample_arrived_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // activity detector gating and queue freeze
    activity_gate u_activity_gate (
        .clk            (clk),
        .rst            (rst),
        .in_watch_samp  (state_q == accel_status_pkg::st_watch_samp),
        .activity_raw   (activity_raw),
        .flag_cleared   (clear_req),
        .rearm_on_clear (rearm_on_clear),
        .freeze_enable  (freeze_enable),
        .stream_enable  (stream_enable),
        .fire           (act_fire),
        .armed_q        (armed_q),
        .freeze_q       (freeze_q)
    );

    // no queue work while asleep, idle or merely watching
    always_ff @(posedge clk) begin
        if (rst) begin
            capture_q <= 1'b0;
        end else begin
            capture_q <= ((state_d == accel_status_pkg::st_continuous_wake)
                       || (state_d == accel_status_pkg::st_watch_samp)
                       || (state_d == accel_status_pkg::st_burst))
                       && !freeze_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt flag conditions
    // levels or pulses here; the bank turns each rise into one set
    assign acq_mode = (state_q == accel_status_pkg::st_continuous_wake) || (state_q == accel_status_pkg::st_burst);

    assign irq_bus.cond[accel_status_pkg::wake_idx]     = auto_wake;
    assign irq_bus.cond[accel_status_pkg::acquired_idx] = sample_written && acq_mode;
    assign irq_bus.cond[accel_status_pkg::empty_idx]    = is_empty;
    assign irq_bus.cond[accel_status_pkg::full_idx]     = is_full;
    assign irq_bus.cond[accel_status_pkg::thresh_idx]   = at_thresh;
    assign irq_bus.cond[accel_status_pkg::activity_idx] = act_fire;
    assign irq_bus.enable = irq_enable;
    assign irq_bus.clear  = clear_req;

    sticky_flag_bank #(
        .N (accel_status_pkg::flag_count)
    ) u_flags (
        .clk (clk),
        .rst (rst),
        .bus (irq_bus)
    );

    // summary bit registered from the flags themselves
    always_ff @(posedge clk) begin
        if (rst) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= |irq_bus.flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data assembly
    always_comb begin
        status_word = accel_status_pkg::mode_queue_status_rst;
        status_word[accel_status_pkg::mode_lsb +: accel_status_pkg::mode_width] =
            lag_q[accel_status_pkg::mode_lag_cycles-1];
        status_word[accel_status_pkg::sample_arrived_bit] = sample_arrived_q;
        status_word[accel_status_pkg::queue_empty_bit]    = queue_empty_q;
        status_word[accel_status_pkg::queue_full_bit]     = queue_full_q;
        status_word[accel_status_pkg::queue_thresh_bit]   = queue_thresh_q;
        status_word[accel_status_pkg::any_pending_bit]    = |irq_bus.flags;
    end

    // low two bits are never driven, so writes cannot reach them
    always_comb begin
        flag_word = accel_status_pkg::irq_flag_status_rst;
        flag_word[accel_status_pkg::flag_lsb +: accel_status_pkg::flag_count] = irq_bus.flags;
    end

    // one-cycle read latency; other addresses belong to neighbouring blocks and read zero here
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q  <= accel_status_pkg::rdata_rst;
        end else begin
            if (rd_status) begin
                rdata_q <= status_word;
            end else if (rd_flags) begin
                rdata_q <= flag_word;
            end else if (reg_rd) begin
                rdata_q <= accel_status_pkg::rdata_rst;
            end
        end
    end

    // answer strobe, high one cycle after each read
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    // all flops, nothing combinational leaves the block
    assign reg_rdata        = rdata_q;
    assign reg_rvalid       = rvalid_q;
    assign mode_code        = lag_q[accel_status_pkg::mode_lag_cycles-1];
    assign any_irq_pending  = pending_q;
    assign queue_capture_en = capture_q;
    assign detector_armed   = armed_q;

endmodule : accel_status_irq

//--- tb/accel_status_chk.sv
// port assertions for the status and flag block
`timescale 1ns/100ps
module accel_status_chk (
    input wire logic       clk, rst, reg_rd, reg_rvalid, any_irq_pending, detector_armed, mode_cmd_wr,
    input wire logic [7:0] reg_addr, reg_rdata,
    input wire logic [2:0] mode_code, mode_cmd,
    input wire logic [5:0] irq_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence rd_s(a); reg_rd && reg_addr == a; endsequence
    sequence stby_s; mode_cmd_wr && mode_cmd == accel_status_pkg::code_standby; endsequence
    read_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    lone_answer_a: assert property (!reg_rd |=> !reg_rvalid) else $error("answer without read");
    unmapped_zero_a: assert property (reg_rd && reg_addr != 8'h08 && reg_addr != 8'h09 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    flag_rsv_a: assert property (rd_s(8'h09) |=> reg_rdata[1:0] == 2'h0) else $error("low flag bits set");
    mode_lag_a: assert property (stby_s |-> ##[1:4] mode_code == accel_status_pkg::code_standby)
        else $error("mode field too slow");
    mode_rsv_a: assert property (mode_code != 3'h3 && mode_code != 3'h4) else $error("reserved mode");
    enable_gate_a: assert property ($rose(any_irq_pending) |-> $past(irq_enable) != 6'h0 ||
        $past(irq_enable, 2) != 6'h0) else $error("flag set while disabled");
    pend_or_a: assert property (rd_s(8'h08) |=> reg_rdata[7] == any_irq_pending) else $error("pending bit");
    rst_state_a: assert property (disable iff (1'b0) rst |=> mode_code == 3'h0 && !reg_rvalid && detector_armed)
        else $error("reset state wrong");
endmodule : accel_status_chk
bind accel_status_irq accel_status_chk chk (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
    .any_irq_pending(any_irq_pending), .detector_armed(detector_armed), .mode_cmd_wr(mode_cmd_wr),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .mode_code(mode_code), .mode_cmd(mode_cmd),
    .irq_enable(irq_enable));

//--- tb/host_model.sv
// host side of the register port, one byte per access
`timescale 1ns/100ps
module host_model (
    input  wire logic       clk, reg_rvalid,
    input  wire logic [7:0] reg_rdata,
    output logic            reg_rd = 1'b0, reg_wr = 1'b0,
    output logic [7:0]      reg_addr = 8'h00, reg_wdata = 8'h00
);
    // read pulse, answer taken one edge later; address inverted once released
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk);
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask : rd
    // write pulse, used to clear flags over spi
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~v;
    endtask : wr
endmodule : host_model

//--- tb/tb_top.sv
// self-checking bench for the status and flag block
`timescale 1ns/100ps
module tb_top;
    logic       clk = 1'b0, rst = 1'b1, spi = 1'b0, cmd_wr = 1'b0, smp = 1'b0, act = 1'b0, rd, wr, rv, pend;
    logic       wcs = 1'b0, cap;
    logic [2:0] cmd = 3'h0, mode;
    logic [4:0] thr = 5'h10;
    logic [5:0] en = 6'h00, cnt = 6'h00;
    logic [7:0] addr, wd, rdat, d;
    int         error_cnt = 0, check_count = 0, cycles = 0;
    localparam logic [2:0] codes [8] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7, 3'h3, 3'h4, 3'h0};
    accel_status_irq uut (.clk(clk), .rst(rst), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd),
        .host_is_spi(spi), .reg_rdata(rdat), .reg_rvalid(rv), .mode_cmd_wr(cmd_wr), .mode_cmd(cmd),
        .burst_len(8'h03), .irq_enable(en), .wr_clear_sel(wcs), .rearm_on_clear(1'b0), .freeze_enable(1'b0),
        .stream_enable(1'b0), .queue_thresh(thr), .sample_written(smp), .activity_raw(act), .queue_count(cnt),
        .mode_code(mode), .any_irq_pending(pend), .queue_capture_en(cap), .detector_armed());
    host_model host (.clk(clk), .reg_rvalid(rv), .reg_rdata(rdat), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
        .reg_wdata(wd));
    ////////////////////////////////////////////////////////////
    // clock, and a hang limit well above the few hundred cycles used
    initial forever #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // expected level bits of the status byte
    function automatic logic [7:0] lvl(input logic [5:0] c, input logic [4:0] t);
        return {1'b0, c >= {1'b0, t}, c == 6'h20, c == 6'h00, 4'h8};
    endfunction : lvl
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic mode_to(input logic [2:0] c);
        @(posedge clk);
        cmd_wr <= 1'b1;
        cmd <= c;
        @(posedge clk);
        cmd_wr <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : mode_to
    task automatic report_and_stop;
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////
    // reset values, mode codes, wake, random levels, spi clearing
    initial begin
        void'($urandom(32'h6f8ec4d9));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        host.rd(8'h08, d);
        chk(d, 8'h10);
        host.rd(8'h09, d);
        chk(d, 8'h00);
        host.rd(8'h42, d);
        chk(d, 8'h00);
        foreach (codes[i]) begin
            mode_to(codes[i]);
            host.rd(8'h08, d);
            chk({5'h0, d[2:0]}, {5'h0, codes[i] inside {3'h3, 3'h4} ? 3'h7 : codes[i]});
        end
        en <= 6'h3f;
        mode_to(3'h2);
        chk({7'h0, cap}, 8'h00);
        act <= 1'b1;
        @(posedge clk);
        act <= 1'b0;
        repeat (4) @(posedge clk);
        host.rd(8'h08, d);
        chk({5'h0, d[2:0]}, 8'h05);
        host.rd(8'h09, d);
        chk(d & 8'h07, 8'h04);
        host.rd(8'h09, d);
        chk(d & 8'h04, 8'h00);
        for (int k = 0; k < 20; k++) begin
            cnt <= (k < 2) ? 6'(k * 32) : 6'($urandom_range(32, 0));
            thr <= 5'($urandom);
            smp <= 1'b1;
            @(posedge clk);
            smp <= 1'b0;
            repeat (2) @(posedge clk);
            host.rd(8'h08, d);
            chk(d & 8'h78, lvl(cnt, thr));
        end
        spi <= 1'b1;
        host.rd(8'h09, d);
        chk({d[6:5], d[3], 4'h0, pend}, 8'he1);
        host.wr(8'h09, 8'hff);
        repeat (2) @(posedge clk);
        host.rd(8'h08, d);
        chk({d[7], 6'h0, pend}, 8'h00);
        spi <= 1'b0;
        wcs <= 1'b1;
        cnt <= 6'h00;
        @(posedge clk);
        cnt <= 6'h20;
        host.rd(8'h09, d);
        host.rd(8'h09, d);
        chk(d & 8'h20, 8'h20);
        host.wr(8'h09, 8'h00);
        host.rd(8'h09, d);
        chk(d & 8'h20, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
